/* shared/oscc_pkg.sv */
// What this block does
// - Sixteen-bit command in, sixteen-bit status out
// - Both words shift most significant bit first
// - Command applied only at chip select rise
// - Bits 0-7 switch channels 1-8 on
// - Bits 8-15 enable open-load detection currents
// - Status upper eight bits always zero
// - Status bits 0-7 flag channel faults
// - Previous status shifts out during new command
// - Off open load reported only with detection
// - Overcurrent and short to supply reported
// - Overvoltage turns all off, recovery restores
// - Overtemperature turns off only that channel
// - Sleep resets command: outputs, currents off
// - Host commands all off before sleep; oscc_host just drops enable on a write and sends no all-off frame
// - Host spaces writes over 300 microseconds
// - Host classifies faults using sent command; oscc_host only stores the status word in rx_word
// - Shift register passes data through chain
// - Parallel devices use own chip selects
// - Sample input on fall, shift on rise
// - Chip select high: ignore clock, release output
// - Accept frames of 16 plus 8n pulses
// - Direct inputs ORed into channels five, six
`default_nettype none
package oscc_pkg;

    // ---------------------------------------------
    // Word layout
    // ---------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int CH = 8;
    localparam int CMD_ON_LSB = 0;
    localparam int CMD_DET_LSB = 8;
    localparam logic [WORD_BITS-1:0] CMD_RESET = 16'h0000;
    localparam logic [CH-1:0] STAT_UPPER = 8'h00;
    localparam int PWM5_CH = 4;
    localparam int PWM6_CH = 5;

    // ---------------------------------------------
    // Frame counting
    // ---------------------------------------------
    localparam int FCNT_W = 5;
    localparam logic [FCNT_W-1:0] FRAME_MIN_LAST = 5'h0f;
    localparam logic [FCNT_W-1:0] FRAME_LEN = 5'h10;
    localparam logic [2:0] STEP_MOD = 3'h0;

    // ---------------------------------------------
    // Host timing
    // ---------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int GAP_US = 300;
    localparam int GAP_CYC = GAP_US * CLK_MHZ + 1;
    localparam int GAP_W = 17;
    localparam logic [3:0] SCLK_HALF_LAST = 4'h7;

    // ---------------------------------------------
    // Host register map
    // ---------------------------------------------
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_RX = 8'h0c;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_EN_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_EN_BIT = 1;

endpackage
`default_nettype wire

/* shared/oscc_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface oscc_if;
    logic cs_n;
    logic sclk;
    logic serial_command_input;
    logic status_out;
    logic status_out_oe;
    logic enable;

    modport device (
        input cs_n,
        input sclk,
        input serial_command_input,
        input enable,
        output status_out,
        output status_out_oe
    );

    modport host (
        output cs_n,
        output sclk,
        output serial_command_input,
        output enable,
        input status_out,
        input status_out_oe
    );
endinterface
`default_nettype wire

/* rtl/oscc_device.sv */
`timescale 1ns/100ps
`default_nettype none
module oscc_device (
    input wire logic clk_i,                            // System clock
    input wire logic rst_i,                            // Sync reset
    oscc_if.device link,                               // Serial link
    input wire logic direct_pwm_input_five_i,          // Direct drive ch5
    input wire logic direct_pwm_input_six_i,           // Direct drive ch6
    input wire logic [oscc_pkg::CH-1:0] short_i,       // Overcurrent sense
    input wire logic [oscc_pkg::CH-1:0] open_load_i,   // Off open-load sense
    input wire logic [oscc_pkg::CH-1:0] thermal_limit_i, // Overtemp sense
    input wire logic overvoltage_i,                    // Supply overvoltage
    output logic [oscc_pkg::CH-1:0] channel_on_o,      // Channel drive
    output logic [oscc_pkg::CH-1:0] detect_current_o,  // Detect current on
    output logic [oscc_pkg::WORD_BITS-1:0] command_o   // Applied command
);
    import oscc_pkg::*;

    // ---------------------------------------------
    // Input synchronisers
    // ---------------------------------------------
    localparam int SYNC_W = 3 * CH + 7;
    // Reset to idle pin levels, else a false select edge follows reset
    localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'b1, {(SYNC_W-1){1'b0}}};

    logic [SYNC_W-1:0] sync_raw;
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;

    assign sync_raw = {link.cs_n, link.sclk, link.serial_command_input,
                       link.enable, direct_pwm_input_five_i,
                       direct_pwm_input_six_i, overvoltage_i,
                       short_i, open_load_i, thermal_limit_i};

    // All pins come from outside the clock domain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= SYNC_IDLE;
            sync2 <= SYNC_IDLE;
        end else begin
            sync1 <= sync_raw;
            sync2 <= sync1;
        end
    end

    wire cs_n_s = sync2[SYNC_W-1];
    wire sclk_s = sync2[SYNC_W-2];
    wire sdi_s = sync2[SYNC_W-3];
    wire en_s = sync2[SYNC_W-4];
    wire pwm5_s = sync2[SYNC_W-5];
    wire pwm6_s = sync2[SYNC_W-6];
    wire ov_s = sync2[SYNC_W-7];
    wire [CH-1:0] short_s = sync2[3*CH-1:2*CH];
    wire [CH-1:0] open_s = sync2[2*CH-1:CH];
    wire [CH-1:0] therm_s = sync2[CH-1:0];

    // ---------------------------------------------
    // Edge detection
    // ---------------------------------------------
    logic cs_n_q;
    logic sclk_q;
    logic en_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            en_q <= 1'b0;
        end else begin
            cs_n_q <= cs_n_s;
            sclk_q <= sclk_s;
            en_q <= en_s;
        end
    end

    // Clock edges count only inside a selected frame
    wire selected = ~cs_n_s;
    wire sclk_rise = selected & sclk_s & ~sclk_q;
    wire sclk_fall = selected & ~sclk_s & sclk_q;
    wire cs_fall = ~cs_n_s & cs_n_q;
    wire cs_rise = cs_n_s & ~cs_n_q;
    wire sleep = ~en_s;
    wire power_on = en_s & ~en_q;

    // ---------------------------------------------
    // Fault gathering
    // ---------------------------------------------
    logic [WORD_BITS-1:0] command;
    logic [CH-1:0] fault_latch;

    wire [CH-1:0] cmd_on = command[CMD_ON_LSB +: CH];
    wire [CH-1:0] cmd_det = command[CMD_DET_LSB +: CH];

    // Direct inputs only add drive, never remove it
    wire [CH-1:0] pwm_mask = ({{(CH-1){1'b0}}, pwm5_s} << PWM5_CH)
                           | ({{(CH-1){1'b0}}, pwm6_s} << PWM6_CH);
    wire [CH-1:0] drive_req = cmd_on | pwm_mask;

    // Open load counts only on an off channel with detection on
    wire [CH-1:0] open_flt = open_s & cmd_det & ~drive_req;
    wire [CH-1:0] fault_now = short_s | therm_s | open_flt;

    // New fault in the capture cycle survives into the next word
    always_ff @(posedge clk_i) begin
        if (rst_i || sleep) begin
            fault_latch <= '0;
        end else if (cs_fall) begin
            fault_latch <= fault_now;
        end else begin
            fault_latch <= fault_latch | fault_now;
        end
    end

    // ---------------------------------------------
    // Shift register
    // ---------------------------------------------
    logic [WORD_BITS-1:0] shreg;
    logic status_bit;

    wire [WORD_BITS-1:0] status_word = {STAT_UPPER, fault_latch};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shreg <= '0;
        end else if (cs_fall) begin
            shreg <= status_word;
        end else if (sclk_fall) begin
            shreg <= {shreg[WORD_BITS-2:0], sdi_s};
        end
    end

    // Output bit loads the MSB at select fall, then moves only on clock rise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_bit <= 1'b0;
        end else if (cs_fall) begin
            status_bit <= status_word[WORD_BITS-1];
        end else if (sclk_rise) begin
            status_bit <= shreg[WORD_BITS-1];
        end
    end

    assign link.status_out = status_bit;
    assign link.status_out_oe = selected;

    // ---------------------------------------------
    // Frame length check
    // ---------------------------------------------
    logic [FCNT_W-1:0] pulse_cnt;
    logic reached_min;

    // Counter wraps; only the low three bits matter past sixteen
    always_ff @(posedge clk_i) begin
        if (rst_i || cs_fall) begin
            pulse_cnt <= '0;
            reached_min <= 1'b0;
        end else if (sclk_fall) begin
            pulse_cnt <= pulse_cnt + 5'h01;
            if (pulse_cnt == FRAME_MIN_LAST) begin
                reached_min <= 1'b1;
            end
        end
    end

    wire frame_ok = reached_min & (pulse_cnt[2:0] == STEP_MOD);

    // ---------------------------------------------
    // Command register
    // ---------------------------------------------
    // Last sixteen bits shifted in are the command
    always_ff @(posedge clk_i) begin
        if (rst_i || sleep || power_on) begin
            command <= CMD_RESET;
        end else if (cs_rise && frame_ok) begin
            command <= shreg;
        end
    end

    // ---------------------------------------------
    // Drivers
    // ---------------------------------------------
    // Protection gates drive without touching the command,
    // so recovery restores the commanded state by itself
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_on_o <= '0;
            detect_current_o <= '0;
        end else begin
            channel_on_o <= drive_req & ~therm_s & {CH{~ov_s & en_s}};
            detect_current_o <= cmd_det & {CH{en_s}};
        end
    end

    assign command_o = command;

endmodule
`default_nettype wire

/* rtl/oscc_host.sv */
`timescale 1ns/100ps
`default_nettype none
module oscc_host #(
    parameter int GAP_CYCLES = oscc_pkg::GAP_CYC       // Min write spacing
) (
    input wire logic clk_i,                            // System clock
    input wire logic rst_i,                            // Sync reset
    input wire logic wb_cyc_i,                         // Wishbone cycle
    input wire logic wb_stb_i,                         // Wishbone strobe
    input wire logic wb_we_i,                          // Write enable
    input wire logic [7:0] wb_adr_i,                   // Byte address
    input wire logic [3:0] wb_sel_i,                   // Byte lanes
    input wire logic [31:0] wb_dat_i,                  // Write data
    output logic [31:0] wb_dat_o,                      // Read data
    output logic wb_ack_o,                             // Acknowledge
    oscc_if.host link                                  // Serial link
);
    import oscc_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_LEAD, H_HIGH, H_LOW, H_TRAIL} oscc_hst_t;

    // ---------------------------------------------
    // Wishbone slave
    // ---------------------------------------------
    logic [WORD_BITS-1:0] cmd_word;
    logic [WORD_BITS-1:0] rx_word;
    logic en_ctrl;
    logic busy;

    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // Writes land at the edge where the master sees ack
    wire wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
    wire hit_cmd = wb_adr_i == ADDR_CMD;
    wire hit_ctrl = wb_adr_i == ADDR_CTRL;
    wire start = wr & hit_ctrl & wb_sel_i[0] & wb_dat_i[CTRL_START_BIT];

    wire [31:0] rd_mux = hit_cmd ? {16'h0000, cmd_word}
                       : hit_ctrl ? {30'h0, en_ctrl, 1'b0}
                       : (wb_adr_i == ADDR_STAT) ? {30'h0, en_ctrl, busy}
                       : (wb_adr_i == ADDR_RX) ? {16'h0000, rx_word}
                       : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            cmd_word <= CMD_RESET;
            en_ctrl <= 1'b0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= rd_mux;
            if (wr && hit_cmd && wb_sel_i[0]) begin
                cmd_word[7:0] <= wb_dat_i[7:0];
            end
            if (wr && hit_cmd && wb_sel_i[1]) begin
                cmd_word[15:8] <= wb_dat_i[15:8];
            end
            // Enable follows the written bit; nothing commands all off first
            if (wr && hit_ctrl && wb_sel_i[0]) begin
                en_ctrl <= wb_dat_i[CTRL_EN_BIT];
            end
        end
    end

    // ---------------------------------------------
    // Status input synchroniser
    // ---------------------------------------------
    logic sdo1;
    logic sdo2;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sdo1 <= 1'b0;
            sdo2 <= 1'b0;
        end else begin
            sdo1 <= link.status_out;
            sdo2 <= sdo1;
        end
    end

    // ---------------------------------------------
    // Frame engine
    // ---------------------------------------------
    oscc_hst_t state;
    logic [3:0] timer;
    logic [FCNT_W-1:0] bits;
    logic [WORD_BITS-1:0] tx;
    logic [WORD_BITS-1:0] rx;
    logic [GAP_W-1:0] gap;
    logic cs_n;
    logic sclk;
    logic mosi;

    wire half_done = timer == SCLK_HALF_LAST;
    wire go = start & (state == H_IDLE) & (gap == '0);

    assign busy = (state != H_IDLE) | (gap != '0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= H_IDLE;
            timer <= '0;
            bits <= '0;
            tx <= '0;
            rx <= '0;
            rx_word <= '0;
            gap <= '0;
            cs_n <= 1'b1;
            sclk <= 1'b0;
            mosi <= 1'b0;
        end else begin
            timer <= (state == H_IDLE || half_done) ? 4'h0 : timer + 4'h1;
            if (gap != '0) begin
                gap <= gap - 17'h00001;
            end
            case (state)
                H_IDLE: begin
                    if (go) begin
                        cs_n <= 1'b0;
                        tx <= cmd_word;
                        bits <= '0;
                        state <= H_LEAD;
                    end
                end
                H_LEAD, H_LOW: begin
                    if (half_done) begin
                        if (state == H_LOW && bits == FRAME_LEN) begin
                            state <= H_TRAIL;
                        end else begin
                            // Data moves on rise, device samples on fall
                            sclk <= 1'b1;
                            mosi <= tx[WORD_BITS-1];
                            tx <= {tx[WORD_BITS-2:0], 1'b0};
                            state <= H_HIGH;
                        end
                    end
                end
                H_HIGH: begin
                    if (half_done) begin
                        sclk <= 1'b0;
                        rx <= {rx[WORD_BITS-2:0], sdo2};
                        bits <= bits + 5'h01;
                        state <= H_LOW;
                    end
                end
                H_TRAIL: begin
                    if (half_done) begin
                        cs_n <= 1'b1;
                        mosi <= 1'b0;
                        rx_word <= rx;
                        gap <= GAP_CYCLES[GAP_W-1:0];
                        state <= H_IDLE;
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end

    assign link.cs_n = cs_n;
    assign link.sclk = sclk;
    assign link.serial_command_input = mosi;
    assign link.enable = en_ctrl;

endmodule
`default_nettype wire

/* sim/oscc_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module oscc_assertions (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Sync reset
    input wire logic cs_n, // Chip select
    input wire logic sclk, // Shift clock
    input wire logic status_out, // Device data
    input wire logic status_out_oe, // Device drive
    input wire logic enable, // Device enable
    input wire logic overvoltage_i, // Overvoltage
    input wire logic [oscc_pkg::CH-1:0] channel_on_o, // Drive
    input wire logic [oscc_pkg::CH-1:0] detect_current_o, // Detect
    input wire logic [oscc_pkg::WORD_BITS-1:0] command_o // Command
);
    import oscc_pkg::*;
    // ---------------------------------------------
    // Frame tracking
    // ---------------------------------------------
    logic [7:0] lo_cnt, hi_cnt, cmd_d;
    logic [4:0] rise_cnt;
    logic sclk_d;
    wire [7:0] next_lo_cnt = cs_n ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hff};
    wire [7:0] next_hi_cnt = !cs_n ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hff};
    wire [4:0] next_rise_cnt = cs_n ? 5'h00 : rise_cnt + {4'h0, sclk && !sclk_d};
    always_ff @(posedge clk_i) begin
        lo_cnt <= rst_i ? 8'h00 : next_lo_cnt;
        hi_cnt <= rst_i ? 8'h00 : next_hi_cnt;
        rise_cnt <= rst_i ? 5'h00 : next_rise_cnt;
        sclk_d <= sclk;
        cmd_d <= command_o[7:0];
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ---------------------------------------------
    // Properties
    // ---------------------------------------------
    property p_oe_released; cs_n [*6] |-> !status_out_oe; endproperty
    a_oe_released: assert property (p_oe_released) else $error("data driven while deselected");
    property p_oe_on; !cs_n [*6] |-> status_out_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("data not driven in frame");
    property p_cmd_at_rise; $changed(command_o) && enable |-> hi_cnt inside {[1:8]}; endproperty
    a_cmd_at_rise: assert property (p_cmd_at_rise) else $error("command changed away from select rise");
    property p_sleep_clear;
        !enable [*8] |-> command_o == CMD_RESET && channel_on_o == 8'h00 && detect_current_o == 8'h00;
    endproperty
    a_sleep_clear: assert property (p_sleep_clear) else $error("sleep left state set");
    property p_detect; enable [*8] ##0 $stable(command_o) |-> detect_current_o == command_o[15:8]; endproperty
    a_detect: assert property (p_detect) else $error("detect current differs from command");
    property p_ov_off; overvoltage_i [*6] |-> channel_on_o == 8'h00; endproperty
    a_ov_off: assert property (p_ov_off) else $error("channel on in overvoltage");
    property p_on_needs_cmd; (channel_on_o & ~(command_o[7:0] | cmd_d) & 8'hcf) == 8'h00; endproperty
    a_on_needs_cmd: assert property (p_on_needs_cmd) else $error("channel on without command");
    property p_upper_zero; !cs_n && lo_cnt >= 8'h08 && rise_cnt < 5'h08 |-> !status_out; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("status upper byte not zero");
    property p_sclk_quiet; $changed(cs_n) |-> !sclk && !$past(sclk); endproperty
    a_sclk_quiet: assert property (p_sclk_quiet) else $error("select moved with clock high");
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import oscc_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, ack, pwm5, pwm6, ov, b_cs_n, b_sclk, b_sdi;
    logic [7:0] adr, short_s, open_s, therm_s, chan, det, chan2;
    logic [31:0] dat_w, dat_r, q, rx;
    logic [15:0] cmd, cmd2;
    int n_errors = 0;
    int n_compared = 0;
    int lens[3] = '{15, 17, 24};
    oscc_if lnk();
    oscc_if lnk2();
    // Second link driven by the bench with its own select
    assign lnk2.cs_n = b_cs_n;
    assign lnk2.sclk = b_sclk;
    assign lnk2.serial_command_input = b_sdi;
    assign lnk2.enable = 1'b1;
    oscc_host #(.GAP_CYCLES(50)) i_oscc_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .link(lnk));
    oscc_device i_oscc_device (.clk_i(clk_i), .rst_i(rst_i), .link(lnk), .direct_pwm_input_five_i(pwm5),
        .direct_pwm_input_six_i(pwm6), .short_i(short_s), .open_load_i(open_s), .thermal_limit_i(therm_s),
        .overvoltage_i(ov), .channel_on_o(chan), .detect_current_o(det), .command_o(cmd));
    oscc_device i_oscc_device2 (.clk_i(clk_i), .rst_i(rst_i), .link(lnk2), .direct_pwm_input_five_i(pwm5),
        .direct_pwm_input_six_i(pwm6), .short_i(short_s), .open_load_i(open_s), .thermal_limit_i(therm_s),
        .overvoltage_i(ov), .channel_on_o(chan2), .detect_current_o(), .command_o(cmd2));
    oscc_assertions i_oscc_assertions (.clk_i(clk_i), .rst_i(rst_i), .cs_n(lnk.cs_n), .sclk(lnk.sclk),
        .status_out(lnk.status_out), .status_out_oe(lnk.status_out_oe), .enable(lnk.enable),
        .overvoltage_i(ov), .channel_on_o(chan), .detect_current_o(det), .command_o(cmd));
    // ---------------------------------------------
    // Tasks
    // ---------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        r = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic frame(input logic [15:0] c, output logic [31:0] r);
        logic [31:0] s;
        wb(1'b1, ADDR_CMD, {16'h0000, c}, s);
        wb(1'b1, ADDR_CTRL, 32'h3, s);
        do begin
            wb(1'b0, ADDR_STAT, 32'h0, s);
        end while (s[STAT_BUSY_BIT] !== 1'b0);
        wb(1'b0, ADDR_RX, 32'h0, r);
    endtask
    // Bench as link master: drive on rise, sample on fall
    task automatic bb(input int len, input logic [31:0] d, output logic [31:0] got);
        got = 32'h0;
        b_cs_n <= 1'b0;
        repeat (8) @(posedge clk_i);
        for (int i = len - 1; i >= 0; i--) begin
            b_sclk <= 1'b1;
            b_sdi <= d[i];
            repeat (8) @(posedge clk_i);
            b_sclk <= 1'b0;
            got = {got[30:0], lnk2.status_out};
            repeat (8) @(posedge clk_i);
        end
        b_cs_n <= 1'b1;
        repeat (20) @(posedge clk_i);
    endtask
    // ---------------------------------------------
    // Sequence
    // ---------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        print_verdict;
    end
    initial begin
        {rst_i, cyc, stb, we, pwm5, pwm6, ov, b_cs_n, b_sclk, b_sdi} = 10'h204;
        {adr, short_s, open_s, therm_s, dat_w} = '0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({cmd, det, chan}, 32'h0);
        wb(1'b1, 8'h10, 32'hffff, q);
        wb(1'b0, 8'h10, 32'h0, q);
        chk(q, 32'h0);
        wb(1'b1, ADDR_CTRL, 32'h2, q);
        wb(1'b0, ADDR_STAT, 32'h0, q);
        chk(q, 32'h2);
        repeat (8) @(posedge clk_i);
        frame(16'ha5c3, rx);
        chk(rx, 32'h0);
        chk({cmd, det, chan}, 32'ha5c3_a5c3);
        short_s <= 8'h01;
        therm_s <= 8'h02;
        open_s <= 8'h4c;
        repeat (10) @(posedge clk_i);
        chk({24'h0, chan}, 32'hc1);
        frame(16'ha5c3, rx);
        chk(rx, 32'h0007);
        chk({16'h0, rx[7:0] & 8'hc3, rx[7:0] & ~8'hc3}, 32'h0304);
        therm_s <= 8'h00;
        ov <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk({cmd, 8'h00, chan}, 32'ha5c3_0000);
        ov <= 1'b0;
        pwm5 <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk({24'h0, chan}, 32'hd3);
        pwm5 <= 1'b0;
        pwm6 <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk({24'h0, chan}, 32'he3);
        pwm6 <= 1'b0;
        wb(1'b1, ADDR_CTRL, 32'h0, q);
        repeat (10) @(posedge clk_i);
        chk({cmd, det, chan}, 32'h0);
        wb(1'b1, ADDR_CTRL, 32'h2, q);
        repeat (10) @(posedge clk_i);
        chk({16'h0, cmd}, 32'h0);
        open_s <= 8'h00;
        bb(16, 32'h1234, q);
        chk(q, 32'h0003);
        chk({16'h0, cmd2}, 32'h1234);
        for (int k = 0; k < 3; k++) begin
            bb(lens[k], 32'h00ab5a96, q);
            chk({16'h0, cmd2}, {16'h0, (k == 2) ? 16'h5a96 : 16'h1234});
        end
        bb(32, 32'hbeef0f0f, q);
        chk({16'h0, q[15:0]}, 32'hbeef);
        chk({16'h0, q[31:16]}, 32'h0001);
        chk({16'h0, cmd2}, 32'h0f0f);
        print_verdict;
    end
endmodule
`default_nettype wire
